//--- hdl/spm_top.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RULE1: host erases map before changing it
// RULE2: erase opcode is 3D 2A 7F CF
// RULE3: chip select rise starts the erase
// RULE4: busy shows while erase runs
// RULE5: erase fills map with FF always
// RULE6: erased map blocks array program and erase (code refuses arr_req only while prot_en is set or wp_n is low)
// RULE7: program opcode 3D 2A 7F FC plus data
// RULE8: chip select rise starts program, busy shown
// RULE9: seventeenth data byte wraps to location 0
// RULE10: host sends all sixteen bytes
// RULE11: host writes only valid map values
// RULE12: program accepted with protection on or off
// RULE13: program uses buffer one, overwriting it
// RULE14: read is 32 plus three dummy bytes
// RULE15: read starts at byte 0, runs upward
// RULE16: past sixteen bytes output is undefined
// RULE17: chip select rise ends read, output off
// RULE18: byte n guards sector n
// RULE19: write-protect pin blocks map changes
// RULE20: exact opcode only, busy clears at end
module spm_top
#(
  parameter int ERASE_CYCLES = spm_pkg::T_PE_CYC,
  parameter int PROG_CYCLES = spm_pkg::T_P_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic spi_csn,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic wp_n,
  input wire logic prot_en,
  input wire logic arr_req,
  input wire logic [spm_pkg::IDX_W-1:0] arr_sector,
  output logic arr_grant,
  output logic arr_reject,
  output logic map_busy,
  output logic buf1_hit,
  output logic [spm_pkg::MAP_BYTES-1:0] sector_prot
);
  import spm_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W))
  begin : bad_erase
    $error("erase cycle count out of range");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CNT_W))
  begin : bad_prog
    $error("program cycle count out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    spm_phase_t phase;
    logic sck_q;
    logic csn_q;
    logic [7:0] sh;
    logic [2:0] bitc;
    logic [1:0] bytec;
    logic [IDX_W-1:0] wptr;
    logic [MAP_BYTES-1:0] wrote;
    logic [MAP_BYTES-1:0][7:0] buf1;
    logic [MAP_BYTES-1:0][7:0] map;
    logic [IDX_W:0] rbyte;
    logic [2:0] rbit;
    logic so;
    logic so_oe;
    logic tstart;
    logic kind_prog;
    logic busy;
    logic [MAP_BYTES-1:0] prot;
    logic grant;
    logic reject;
    logic hit;
  } spm_state_t;

  spm_state_t s;
  spm_state_t next_s;
  logic tmr_done;
  logic rise;
  logic fall;
  logic frame_end;
  logic full;
  logic [7:0] byte_v;
  spm_phase_t cur;
  logic [CNT_W-1:0] tcycles;

  assign rise = spi_sck & ~s.sck_q & ~spi_csn;
  assign fall = ~spi_sck & s.sck_q & ~spi_csn;
  assign frame_end = spi_csn & ~s.csn_q;
  assign full = (s.bitc == 3'd7);
  assign byte_v = {s.sh[6:0], spi_si};
  assign tcycles = s.kind_prog ? CNT_W'(PROG_CYCLES) : CNT_W'(ERASE_CYCLES);

  spm_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clock(clock),
    .rstn(rstn),
    .start(s.tstart),
    .cycles(tcycles),
    .done(tmr_done)
  );

  function automatic logic [7:0] pfx(input logic [1:0] idx);
    case (idx)
      2'd0: pfx = OP_PFX0;
      2'd1: pfx = OP_PFX1;
      default: pfx = OP_PFX2;
    endcase
  endfunction : pfx

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_s = s;
    next_s.sck_q = spi_sck;
    next_s.csn_q = spi_csn;
    next_s.tstart = 1'b0;
    next_s.grant = 1'b0;
    next_s.reject = 1'b0;
    next_s.hit = 1'b0;
    cur = s.phase;
    if (s.phase == ST_IDLE)
    begin
      cur = s.busy ? ST_SKIP : ST_CMD;
    end
    if (spi_csn)
    begin
      if (frame_end && wp_n && !s.busy) // see RULE19
      begin
        if (s.phase == ST_ARMED) // see RULE3
        begin
          next_s.tstart = 1'b1;
          next_s.kind_prog = 1'b0;
          next_s.busy = 1'b1; // see RULE4
        end
        else if (s.phase == ST_PDATA) // see RULE8, RULE12
        begin
          next_s.tstart = 1'b1;
          next_s.kind_prog = 1'b1;
          next_s.busy = 1'b1;
        end
      end
      next_s.phase = ST_IDLE;
      next_s.so_oe = 1'b0; // see RULE17
      next_s.bitc = '0;
      next_s.bytec = '0;
    end
    else
    begin
      next_s.phase = cur;
      if (rise)
      begin
        next_s.sh = byte_v;
        next_s.bitc = s.bitc + 3'd1;
        case (cur)
          ST_CMD:
          begin
            if (full)
            begin
              if (s.bytec == 2'd0 && byte_v == OP_READ) // see RULE14
              begin
                next_s.phase = ST_RDUMMY;
              end
              else if (s.bytec != 2'd3 && byte_v == pfx(s.bytec)) // see RULE2
              begin
                next_s.bytec = s.bytec + 2'd1;
              end
              else if (s.bytec == 2'd3 && byte_v == OP_ERASE) // see RULE20
              begin
                next_s.phase = ST_ARMED;
              end
              else if (s.bytec == 2'd3 && byte_v == OP_PROG) // see RULE7
              begin
                next_s.phase = ST_PDATA;
                next_s.wptr = '0;
                next_s.wrote = '0;
                next_s.hit = 1'b1; // see RULE13
              end
              else
              begin
                next_s.phase = ST_SKIP;
              end
            end
          end
          ST_PDATA:
          begin
            if (full)
            begin
              next_s.buf1[s.wptr] = byte_v;
              next_s.wrote[s.wptr] = 1'b1;
              next_s.wptr = s.wptr + 1'b1; // see RULE9
            end
          end
          ST_RDUMMY:
          begin
            if (full)
            begin
              next_s.bytec = s.bytec + 2'd1;
              if (s.bytec == 2'(DUMMY_BYTES - 1))
              begin
                next_s.phase = ST_ROUT;
                next_s.rbyte = '0;
                next_s.rbit = '0;
              end
            end
          end
          ST_ARMED:
          begin
            next_s.phase = ST_SKIP;
          end
          default:
          begin
            next_s.phase = cur;
          end
        endcase
      end
      if (fall && s.phase == ST_ROUT)
      begin
        next_s.so_oe = 1'b1;
        next_s.so = s.rbyte[IDX_W] ? 1'b0 :
          s.map[s.rbyte[IDX_W-1:0]][3'd7 - s.rbit]; // see RULE15
        next_s.rbit = s.rbit + 3'd1;
        if (s.rbit == 3'd7 && !s.rbyte[IDX_W]) // see RULE16
        begin
          next_s.rbyte = s.rbyte + 1'b1;
        end
      end
    end
    if (tmr_done)
    begin
      next_s.busy = 1'b0; // see RULE20
      for (int i = 0; i < MAP_BYTES; i++)
      begin
        if (!s.kind_prog)
        begin
          next_s.map[i] = MAP_ERASED; // see RULE5
        end
        else if (s.wrote[i])
        begin
          next_s.map[i] = s.buf1[i];
        end
      end
    end
    for (int i = 0; i < MAP_BYTES; i++)
    begin
      if (i == 0)
      begin
        next_s.prot[i] = |s.map[i][SEC0_HI:SEC0_LO]; // see RULE18
      end
      else
      begin
        next_s.prot[i] = (s.map[i] != MAP_ZERO);
      end
    end
    if (arr_req)
    begin
      if ((prot_en || !wp_n) && s.prot[arr_sector]) // see RULE6, RULE19
      begin
        next_s.reject = 1'b1;
      end
      else
      begin
        next_s.grant = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.phase <= ST_IDLE;
      s.sck_q <= 1'b0;
      s.csn_q <= 1'b1;
      s.map <= {MAP_BYTES{MAP_RESET}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign spi_so = s.so;
  assign spi_so_oe = s.so_oe;
  assign arr_grant = s.grant;
  assign arr_reject = s.reject;
  assign map_busy = s.busy;
  assign buf1_hit = s.hit;
  assign sector_prot = s.prot;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence erase_end_s;
    frame_end && s.phase == ST_ARMED && wp_n && !s.busy;
  endsequence

  sequence prog_end_s;
    frame_end && s.phase == ST_PDATA && wp_n && !s.busy;
  endsequence

  erase_busy_a: assert property (erase_end_s |=> map_busy ##1 map_busy) // see RULE4
    else $error("erase did not raise busy");
  prog_busy_a: assert property (prog_end_s |=> map_busy && s.kind_prog) // see RULE8
    else $error("program did not raise busy");
  wp_block_a: assert property (frame_end && !wp_n && !s.busy |=> !map_busy) // see RULE19
    else $error("map change started under write protect");
  erase_fill_a: assert property (tmr_done && !s.kind_prog |=> s.map == {MAP_BYTES{MAP_ERASED}}) // see RULE5
    else $error("erase did not fill map");
  busy_clear_a: assert property (tmr_done |=> !map_busy) // see RULE20
    else $error("busy stuck after cycle");
  busy_hold_a: assert property (map_busy && !tmr_done |=> map_busy) // see RULE8
    else $error("busy dropped early");
  wptr_wrap_a: assert property (rise && s.phase == ST_PDATA && full && s.wptr == 4'hF
    |=> s.wptr == '0 && s.wrote[15]) // see RULE9
    else $error("write pointer did not wrap");
  read_first_a: assert property (fall && s.phase == ST_ROUT && s.rbyte == '0 && s.rbit == '0
    |=> spi_so_oe && spi_so == $past(s.map[0][7])) // see RULE15
    else $error("read did not start at byte zero");
  so_off_a: assert property (frame_end |=> !spi_so_oe) // see RULE17
    else $error("output still driven after frame");
  reject_a: assert property (arr_req && prot_en && sector_prot[arr_sector]
    |=> arr_reject && !arr_grant) // see RULE6
    else $error("protected sector not refused");
  buf_hit_a: assert property (rise && cur == ST_CMD && full && s.bytec == 2'd3
    && byte_v == OP_PROG |=> buf1_hit) // see RULE13
    else $error("buffer use not flagged");

endmodule : spm_top

`default_nettype wire

//--- hdl/spm_pkg.sv
// ****************************************
// constants
// ****************************************
package spm_pkg;

  localparam int MAP_BYTES = 16;
  localparam int IDX_W = 4;
  localparam int CMD_BYTES = 4;
  localparam int DUMMY_BYTES = 3;

  // opcode bytes
  localparam logic [7:0] OP_PFX0 = 8'h3D;
  localparam logic [7:0] OP_PFX1 = 8'h2A;
  localparam logic [7:0] OP_PFX2 = 8'h7F;
  localparam logic [7:0] OP_ERASE = 8'hCF;
  localparam logic [7:0] OP_PROG = 8'hFC;
  localparam logic [7:0] OP_READ = 8'h32;

  // map contents
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] MAP_ZERO = 8'h00;
  localparam int SEC0_HI = 7;
  localparam int SEC0_LO = 4;

  // self-timed cycles
  localparam int CLK_MHZ = 125;
  localparam int T_PE_US = 2000;
  localparam int T_P_US = 2000;
  localparam int T_PE_CYC = T_PE_US * CLK_MHZ;
  localparam int T_P_CYC = T_P_US * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_CMD = 7'b000_0010,
    ST_PDATA = 7'b000_0100,
    ST_RDUMMY = 7'b000_1000,
    ST_ROUT = 7'b001_0000,
    ST_ARMED = 7'b010_0000,
    ST_SKIP = 7'b100_0000
  } spm_phase_t;

endpackage : spm_pkg

//--- hdl/spm_timer.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// self-timed cycle counter
// ****************************************
module spm_timer #(
  parameter int CNT_W = 24
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [CNT_W-1:0] cycles,
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic done;
  } spm_tmr_t;

  spm_tmr_t s;
  spm_tmr_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (start)
    begin
      next_s.cnt = cycles - 1'b1;
      next_s.run = 1'b1;
    end
    else if (s.run)
    begin
      if (s.cnt == '0)
      begin
        next_s.run = 1'b0;
        next_s.done = 1'b1;
      end
      else
      begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule : spm_timer

`default_nettype wire

//--- tb/spm_host.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// host spi controller model, mode 0
// ****************************************
module spm_host (
  input wire logic clock,
  input wire logic spi_so,
  output logic spi_csn,
  output logic spi_sck,
  output logic spi_si
);
  int half = 3;

  initial
  begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_cyc

  task automatic begin_frame();
    wait_cyc(1);
    spi_csn = 1'b0;
  endtask : begin_frame

  // msb first, so sampled just before each rise
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      spi_si = d[i];
      wait_cyc(half);
      q[i] = spi_so;
      spi_sck = 1'b1;
      wait_cyc(half);
      spi_sck = 1'b0;
    end
  endtask : xbyte

  task automatic end_frame();
    wait_cyc(half);
    spi_csn = 1'b1;
    spi_si = ~spi_si;
  endtask : end_frame
endmodule : spm_host

`default_nettype wire

//--- tb/tb_sector_protect_map_commands.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// testbench
// ****************************************
module tb_sector_protect_map_commands;
  import spm_pkg::*;
  logic clock;
  logic rstn;
  logic wp_n;
  logic prot_en;
  logic arr_req;
  logic [3:0] arr_sector;
  logic spi_csn, spi_sck, spi_si, spi_so, spi_so_oe;
  logic so_line;
  logic arr_grant, arr_reject, map_busy, buf1_hit, hit_seen;
  logic [15:0] sector_prot;
  int fails = 0;
  int samples_checked = 0;

  always #4 clock = ~clock;
  always @(posedge clock) if (buf1_hit === 1'b1) hit_seen <= 1'b1;
  // undriven output line shows the inverse, so a missing enable is caught
  assign so_line = spi_so_oe ? spi_so : ~spi_so;

  spm_host host (.clock(clock), .spi_so(so_line), .spi_csn(spi_csn), .spi_sck(spi_sck),
    .spi_si(spi_si));
  spm_top #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) dut (.clock(clock), .rstn(rstn),
    .spi_csn(spi_csn), .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .wp_n(wp_n), .prot_en(prot_en), .arr_req(arr_req),
    .arr_sector(arr_sector), .arr_grant(arr_grant), .arr_reject(arr_reject),
    .map_busy(map_busy), .buf1_hit(buf1_hit), .sector_prot(sector_prot));

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] map_exp(input int i);
    return (i % 2 == 1) ? 8'hff : 8'h00;
  endfunction : map_exp

  task automatic cmd(input logic [7:0] op);
    logic [7:0] q;
    host.begin_frame();
    host.xbyte(OP_PFX0, q);
    host.xbyte(OP_PFX1, q);
    host.xbyte(OP_PFX2, q);
    host.xbyte(op, q);
  endtask : cmd

  task automatic busy_cycle();
    host.wait_cyc(3);
    chk(map_busy, 1'b1);
    for (int n = 0; n < 100 && map_busy !== 1'b0; n++) host.wait_cyc(1);
    chk(map_busy, 1'b0);
    host.wait_cyc(2);
  endtask : busy_cycle

  task automatic arr(input logic [3:0] s, input logic [1:0] exp);
    arr_sector = s;
    arr_req = 1'b1;
    host.wait_cyc(1);
    chk({arr_grant, arr_reject}, exp);
    arr_req = 1'b0;
    host.wait_cyc(1);
  endtask : arr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_erase();
    prot_en = 1'b1;
    cmd(OP_ERASE);
    host.end_frame();
    busy_cycle();
    chk(sector_prot, 16'hffff);
    arr(4'h5, 2'b01);
    prot_en = 1'b0;
    arr(4'h5, 2'b10);
  endtask : t_erase

  task automatic t_program();
    logic [7:0] q;
    prot_en = 1'b1;
    hit_seen = 1'b0;
    cmd(OP_PROG);
    host.xbyte(8'hf0, q);
    for (int i = 1; i < 16; i++) host.xbyte(map_exp(i), q);
    host.xbyte(8'h00, q);
    host.end_frame();
    chk(hit_seen, 1'b1);
    busy_cycle();
    chk(sector_prot, 16'haaaa);
    arr(4'h2, 2'b10);
    arr(4'h3, 2'b01);
  endtask : t_program

  task automatic t_read();
    logic [7:0] q;
    host.half = 5;
    host.begin_frame();
    host.xbyte(OP_READ, q);
    for (int i = 0; i < 3; i++) host.xbyte(8'h00, q);
    for (int i = 0; i < 16; i++)
    begin
      host.xbyte(8'h00, q);
      chk(q, map_exp(i));
      chk(spi_so_oe, 1'b1);
    end
    host.xbyte(8'h00, q);
    host.end_frame();
    host.wait_cyc(2);
    chk(spi_so_oe, 1'b0);
    host.half = 3;
  endtask : t_read

  task automatic t_refused();
    logic [7:0] q;
    cmd(8'hce);
    host.end_frame();
    host.wait_cyc(3);
    chk(map_busy, 1'b0);
    wp_n = 1'b0;
    cmd(OP_ERASE);
    host.end_frame();
    host.wait_cyc(3);
    chk(map_busy, 1'b0);
    chk(sector_prot, 16'haaaa);
    prot_en = 1'b0;
    arr(4'h1, 2'b01);
    wp_n = 1'b1;
    cmd(OP_ERASE);
    host.end_frame();
    cmd(OP_PROG);
    for (int i = 0; i < 16; i++) host.xbyte(8'h00, q);
    host.end_frame();
    host.wait_cyc(3);
    chk(map_busy, 1'b0);
    chk(sector_prot, 16'hffff);
  endtask : t_refused

  initial
  begin
    clock = 1'b0;
    rstn = 1'b0;
    wp_n = 1'b1;
    prot_en = 1'b0;
    arr_req = 1'b0;
    arr_sector = 4'h0;
    hit_seen = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rstn = 1'b1;
    host.wait_cyc(1);
    chk({map_busy, spi_so_oe}, 2'b00);
    chk(sector_prot, 16'h0000);
    t_erase();
    t_program();
    t_read();
    t_refused();
    summarize();
  end

  initial
  begin
    repeat (50000) @(posedge clock);
    fails++;
    summarize();
  end
endmodule : tb_sector_protect_map_commands

`default_nettype wire
